//--- verilog/rff_pkg.sv
// Shared constants for the reset and fault-flag block and its host.
// Assumes one 10 MHz clock shared by both ends.
package rff_pkg;

  // Link widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Device register offsets
  localparam logic [7:0] REG_LATCHED  = 8'h00;
  localparam logic [7:0] REG_SUPPLY   = 8'h01;
  localparam logic [7:0] REG_LIVE     = 8'h02;
  localparam logic [7:0] REG_MASK     = 8'h03;
  localparam logic [7:0] REG_KEY      = 8'h04;
  localparam logic [7:0] REG_OVERHEAT = 8'h05;
  localparam logic [7:0] REG_CHAN     = 8'h06;

  // Command keys and clear pattern
  localparam logic [15:0] KEY_FIRST  = 16'h15FA;
  localparam logic [15:0] KEY_SECOND = 16'hAF51;
  localparam logic [15:0] CLEAR_ALL  = 16'hFFFF;

  // Latched and live flag positions
  localparam int FLG_RESTART   = 0;
  localparam int FLG_OVERHEAT  = 1;
  localparam int FLG_FRAME     = 2;
  localparam int FLG_CHAN      = 3;
  localparam int FLG_SUPPLY_LO = 4;
  localparam int N_SUPPLY      = 6;
  // Supply flag register and overheat config positions
  localparam int SUP_TRIM      = 0;
  localparam int CFG_HEAT_EN   = 0;

  // Reset values; channel config zero means high impedance
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] CHAN_RST = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int RST_PULSE_MIN_NS = 1000;
  localparam int RST_PULSE_CYC    = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_TIME_NS    = 1000000;
  localparam int RESET_CYC_DEF    = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host-side register offsets and control bits
  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h01;
  localparam logic [7:0] HREG_DADDR  = 8'h02;
  localparam logic [7:0] HREG_DWDATA = 8'h03;
  localparam logic [7:0] HREG_DRDATA = 8'h04;
  localparam int CTL_PIN_RST = 0;
  localparam int CTL_SW_RST  = 1;
  localparam int CTL_CLEAR   = 2;
  localparam int CTL_WRITE   = 3;
  localparam int CTL_READ    = 4;

  // Device reset sequence states
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11
  } rff_seq_e;

  // Host sequencer states
  typedef enum logic [3:0] {
    H_IDLE    = 4'b0000,
    H_PIN     = 4'b0001,
    H_KEY1    = 4'b0011,
    H_KEY2    = 4'b0010,
    H_WAIT    = 4'b0110,
    H_CLR_SUP = 4'b0111,
    H_CLR_LAT = 4'b0101,
    H_WRITE   = 4'b0100,
    H_READ    = 4'b1100,
    H_CAPT    = 4'b1101
  } rff_host_e;

endpackage

//--- verilog/rff_link_if.sv
// Register link between host and device, plus reset pin and fault pin.
// Both ends run on the same clock; the bench ties them together.
`timescale 1ns/100ps
interface rff_link_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        reset_pin_n;
  logic        fault_n;

  // Device end
  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    input  reset_pin_n,
    output rdata,
    output fault_n
  );

  // Host end
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    output reset_pin_n,
    input  rdata,
    input  fault_n
  );
endinterface

//--- verilog/rff_device.sv
// Reset sequencer and fault flags of the I/O channel device.
// Assumes monitor inputs synchronous to CLK and a host on the link port.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
module rff_device
  import rff_pkg::*;
#(
  parameter int RESET_CYC = RESET_CYC_DEF,
  parameter int PULSE_CYC = RST_PULSE_CYC
)(
  // Clock and power-on reset
  input  wire logic          CLK,
  input  wire logic          NRST,
  // Link to host
  rff_link_if.dev            LINK,
  // Monitors
  input  wire logic          CORE_SUPPLY_OK,
  input  wire logic          INTF_SUPPLY_OK,
  input  wire logic [N_SUPPLY-1:0] SUPPLY_LOW,
  input  wire logic          TEMP_ALERT,
  input  wire logic          TEMP_RESET_HIT,
  input  wire logic          FRAME_ERR,
  input  wire logic          CHAN_FAULT,
  // Channel side
  output logic               CHAN_HIZ,
  output logic               CAL_RELOAD,
  output logic               IN_RESET,
  output logic [15:0]        CHAN_CFG
);

  localparam int CW = $clog2(RESET_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  // Refuse counts the counters cannot serve
  generate
    if (RESET_CYC < 2 || PULSE_CYC < 1)
    begin : g_bad
      $error("rff_device: counts too small");
    end
  endgenerate

  rff_seq_e      state;
  rff_seq_e      next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [PW-1:0] pin_cnt;
  logic [PW-1:0] next_pin_cnt;
  logic [15:0]   latched;
  logic [15:0]   next_latched;
  logic [15:0]   supply;
  logic [15:0]   next_supply;
  logic [15:0]   mask;
  logic [15:0]   next_mask;
  logic [15:0]   chan;
  logic [15:0]   next_chan;
  logic          heat_en;
  logic          next_heat_en;
  logic          key_armed;
  logic          next_key_armed;
  logic [15:0]   rdata;
  logic [15:0]   next_rdata;
  logic          fault_n;
  logic          next_fault_n;
  logic [15:0]   live;
  logic          pin_held;
  logic          hold_req;
  logic          sw_go;
  logic          heat_go;
  logic          seq_done;
  logic          wr_run;

  ////////////////////////////////////////////////////////////////////////
  // Reset requests

  // Live view of the overheat, frame, channel and supply-low conditions, never latched
  // live unlatched view
  always_comb
  begin
    live                = 16'h0000;
    live[FLG_OVERHEAT]  = TEMP_ALERT;
    live[FLG_FRAME]     = FRAME_ERR;
    live[FLG_CHAN]      = CHAN_FAULT;
    live[FLG_SUPPLY_LO +: N_SUPPLY] = SUPPLY_LOW;
  end

  // Pin counts its low time; glitches shorter than the minimum are dropped
  // pin width filter
  assign pin_held = (pin_cnt == PW'(PULSE_CYC));
  assign hold_req = pin_held | ~CORE_SUPPLY_OK | ~INTF_SUPPLY_OK;
  assign wr_run   = (state == ST_RUN) & LINK.wr;
  assign sw_go    = wr_run & (LINK.addr == REG_KEY) & (LINK.wdata == KEY_SECOND) & key_armed;
  assign heat_go  = (state == ST_RUN) & heat_en & TEMP_RESET_HIT;
  assign seq_done = (state == ST_WAIT) & ~hold_req & (cnt == CW'(RESET_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state, counters
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_pin_cnt = LINK.reset_pin_n ? '0 : (pin_held ? pin_cnt : pin_cnt + PW'(1));
    case (state)
      ST_START:
      begin
        next_cnt = '0;
        if (!hold_req)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        next_cnt = cnt + CW'(1);
        if (hold_req)
          next_state = ST_START;
        else if (seq_done)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (hold_req || sw_go || heat_go)
          next_state = ST_START;
      end
      default:
        next_state = ST_START;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state   <= ST_START;
      cnt     <= '0;
      pin_cnt <= '0;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      pin_cnt <= next_pin_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags

  // Writes only land in run; a set always beats a clear in the same cycle
  always_comb
  begin
    next_latched   = latched;
    next_supply    = supply;
    next_mask      = mask;
    next_chan      = chan;
    next_heat_en   = heat_en;
    next_key_armed = key_armed;
    next_rdata     = 16'h0000;
    if (state == ST_START)
    begin
      next_latched   = 16'h0000;
      next_supply    = 16'h0000;
      next_mask      = MASK_RST;
      next_chan      = CHAN_RST;
      next_heat_en   = 1'b0;
      next_key_armed = 1'b0;
    end
    else
    begin
      if (wr_run)
      begin
        next_key_armed = (LINK.addr == REG_KEY) & (LINK.wdata == KEY_FIRST);
        case (LINK.addr)
          REG_LATCHED:  next_latched = latched & ~LINK.wdata;
          REG_SUPPLY:   next_supply  = supply & ~LINK.wdata;
          REG_MASK:     next_mask    = LINK.wdata;
          REG_CHAN:     next_chan    = LINK.wdata;
          REG_OVERHEAT: next_heat_en = LINK.wdata[CFG_HEAT_EN];
          default:      next_chan    = chan;
        endcase
      end
      next_latched = next_latched | live;
      if (seq_done)
        next_latched[FLG_RESTART] = 1'b1;
      if ((state == ST_WAIT) && (LINK.wr || LINK.rd))
        next_supply[SUP_TRIM] = 1'b1;
      if (LINK.rd)
      begin
        case (LINK.addr)
          REG_LATCHED:  next_rdata = latched;
          REG_SUPPLY:   next_rdata = supply;
          REG_LIVE:     next_rdata = live;
          REG_MASK:     next_rdata = mask;
          REG_CHAN:     next_rdata = chan;
          REG_OVERHEAT: next_rdata = {15'h0000, heat_en};
          default:      next_rdata = 16'h0000;
        endcase
      end
    end
    next_fault_n = ~(|(next_latched & ~next_mask) | next_supply[SUP_TRIM]);
  end

  // Register file flops
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      latched   <= 16'h0000;
      supply    <= 16'h0000;
      mask      <= MASK_RST;
      chan      <= CHAN_RST;
      heat_en   <= 1'b0;
      key_armed <= 1'b0;
      rdata     <= 16'h0000;
      fault_n   <= 1'b1;
    end
    else
    begin
      latched   <= next_latched;
      supply    <= next_supply;
      mask      <= next_mask;
      chan      <= next_chan;
      heat_en   <= next_heat_en;
      key_armed <= next_key_armed;
      rdata     <= next_rdata;
      fault_n   <= next_fault_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Channel is forced hi-z until the sequence finishes
  assign LINK.rdata   = rdata;
  assign LINK.fault_n = fault_n;
  assign IN_RESET     = (state != ST_RUN);
  assign CAL_RELOAD   = (state == ST_WAIT);
  assign CHAN_HIZ     = (state != ST_RUN) | (chan == CHAN_RST);
  assign CHAN_CFG     = chan;

endmodule

//--- verilog/rff_host.sv
// Host controller end: drives reset pin and register link for software.
// Assumes software on a plain strobe port; read data one cycle later.
`timescale 1ns/100ps
module rff_host
  import rff_pkg::*;
#(
  parameter int RESET_CYC = RESET_CYC_DEF,
  parameter int PULSE_CYC = RST_PULSE_CYC
)(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Link to device
  rff_link_if.host         LINK,
  // Software port
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA
);

  localparam int CW = $clog2(RESET_CYC + PULSE_CYC + 4);

  // Refuse counts the counters cannot serve
  generate
    if (RESET_CYC < 2 || PULSE_CYC < 1)
    begin : g_bad
      $error("rff_host: counts too small");
    end
  endgenerate

  rff_host_e     state;
  rff_host_e     next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [7:0]    daddr;
  logic [7:0]    next_daddr;
  logic [15:0]   dwdata;
  logic [15:0]   next_dwdata;
  logic [15:0]   drdata;
  logic [15:0]   next_drdata;
  logic [15:0]   rdata;
  logic [15:0]   next_rdata;
  logic [7:0]    l_addr;
  logic [7:0]    next_l_addr;
  logic [15:0]   l_wdata;
  logic [15:0]   next_l_wdata;
  logic          l_wr;
  logic          next_l_wr;
  logic          l_rd;
  logic          next_l_rd;
  logic          l_pin_n;
  logic          next_l_pin_n;
  logic          ctl_go;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Control writes while busy are dropped
  assign ctl_go = WR & (ADDR == HREG_CTRL) & (state == H_IDLE);

  // Next state and counter
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt + CW'(1);
    case (state)
      H_IDLE:
      begin
        next_cnt = '0;
        if (ctl_go)
        begin
          if (WDATA[CTL_PIN_RST])
            next_state = H_PIN;
          else if (WDATA[CTL_SW_RST])
            next_state = H_KEY1;
          else if (WDATA[CTL_CLEAR])
            next_state = H_CLR_SUP;
          else if (WDATA[CTL_WRITE])
            next_state = H_WRITE;
          else if (WDATA[CTL_READ])
            next_state = H_READ;
        end
      end
      H_PIN:
        if (cnt == CW'(PULSE_CYC))
        begin
          next_state = H_WAIT;
          next_cnt   = '0;
        end
      H_KEY1:    next_state = H_KEY2;
      H_KEY2:
      begin
        next_state = H_WAIT;
        next_cnt   = '0;
      end
      H_WAIT:
        if (cnt == CW'(RESET_CYC + 2))
          next_state = H_CLR_SUP;
      H_CLR_SUP: next_state = H_CLR_LAT;
      H_CLR_LAT: next_state = H_IDLE;
      H_WRITE:   next_state = H_IDLE;
      H_READ:    next_state = H_CAPT;
      H_CAPT:    next_state = H_IDLE;
      default:   next_state = H_IDLE;
    endcase
  end

  // Link outputs for the coming state, so they leave flops
  always_comb
  begin
    next_l_addr  = 8'h00;
    next_l_wdata = 16'h0000;
    next_l_wr    = 1'b0;
    next_l_rd    = 1'b0;
    next_l_pin_n = 1'b1;
    case (next_state)
      H_PIN:     next_l_pin_n = 1'b0;
      H_KEY1:
      begin
        next_l_wr = 1'b1; next_l_addr = REG_KEY; next_l_wdata = KEY_FIRST;
      end
      H_KEY2:
      begin
        next_l_wr = 1'b1; next_l_addr = REG_KEY; next_l_wdata = KEY_SECOND;
      end
      H_CLR_SUP:
      begin
        next_l_wr = 1'b1; next_l_addr = REG_SUPPLY; next_l_wdata = CLEAR_ALL;
      end
      H_CLR_LAT:
      begin
        next_l_wr = 1'b1; next_l_addr = REG_LATCHED; next_l_wdata = CLEAR_ALL;
      end
      H_WRITE:
      begin
        next_l_wr = 1'b1; next_l_addr = daddr; next_l_wdata = dwdata;
      end
      H_READ:
      begin
        next_l_rd = 1'b1; next_l_addr = daddr;
      end
      default:   next_l_pin_n = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  // Plain registers plus status; read data one cycle after the strobe
  always_comb
  begin
    next_daddr  = (WR && ADDR == HREG_DADDR)  ? WDATA[7:0] : daddr;
    next_dwdata = (WR && ADDR == HREG_DWDATA) ? WDATA      : dwdata;
    next_drdata = (state == H_CAPT) ? LINK.rdata : drdata;
    next_rdata  = 16'h0000;
    if (RD)
    begin
      case (ADDR)
        HREG_STATUS: next_rdata = {14'h0000, ~LINK.fault_n, state != H_IDLE};
        HREG_DADDR:  next_rdata = {8'h00, daddr};
        HREG_DWDATA: next_rdata = dwdata;
        HREG_DRDATA: next_rdata = drdata;
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  // All host flops
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state   <= H_IDLE;
      cnt     <= '0;
      daddr   <= 8'h00;
      dwdata  <= 16'h0000;
      drdata  <= 16'h0000;
      rdata   <= 16'h0000;
      l_addr  <= 8'h00;
      l_wdata <= 16'h0000;
      l_wr    <= 1'b0;
      l_rd    <= 1'b0;
      l_pin_n <= 1'b1;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      daddr   <= next_daddr;
      dwdata  <= next_dwdata;
      drdata  <= next_drdata;
      rdata   <= next_rdata;
      l_addr  <= next_l_addr;
      l_wdata <= next_l_wdata;
      l_wr    <= next_l_wr;
      l_rd    <= next_l_rd;
      l_pin_n <= next_l_pin_n;
    end
  end

  // Outputs
  assign RDATA            = rdata;
  assign LINK.addr        = l_addr;
  assign LINK.wdata       = l_wdata;
  assign LINK.wr          = l_wr;
  assign LINK.rd          = l_rd;
  assign LINK.reset_pin_n = l_pin_n;

endmodule

//--- verification/rff_link_sva.sv
// Checker on the host-device link: answer timing and fault pin behaviour.
// Assumes one clock and an instance beside the link in the bench.
`timescale 1ns/100ps
module rff_link_chk
  import rff_pkg::*;
#(
  parameter int RESET_CYC = 20
)(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Link signals
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        reset_pin_n,
  input wire logic        fault_n
);
  localparam int RS_HI = RESET_CYC + 8;
  logic [7:0] cyc;
  logic       key1_seen;
  logic       sup_clr_seen;
  logic [7:0] next_cyc;
  logic       next_key1_seen;
  logic       next_sup_clr_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since release, saturating so early-window checks never wrap
  always_comb
  begin
    next_cyc          = (cyc == 8'hFF) ? cyc : cyc + 8'h01;
    next_key1_seen    = wr && addr == REG_KEY && wdata == KEY_FIRST;
    next_sup_clr_seen = wr && addr == REG_SUPPLY && wdata == CLEAR_ALL;
  end

  // Helper flops, cleared with the link
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cyc          <= 8'h00;
      key1_seen    <= 1'b0;
      sup_clr_seen <= 1'b0;
    end
    else
    begin
      cyc          <= next_cyc;
      key1_seen    <= next_key1_seen;
      sup_clr_seen <= next_sup_clr_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties, one clock domain
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_rd_answer;
    rdata != 16'h0000 |-> $past(rd);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data outside its answer cycle");

  property p_live_bit0;
    rd && addr == REG_LIVE |=> !rdata[FLG_RESTART];
  endproperty
  a_live_bit0: assert property (p_live_bit0)
    else $error("live view shows a restart bit");

  property p_key_wo;
    rd && addr == REG_KEY |=> rdata == 16'h0000;
  endproperty
  a_key_wo: assert property (p_key_wo)
    else $error("key register readable");

  property p_trim;
    rd && cyc >= 8'h02 && cyc <= 8'h0A |-> ##[1:4] !fault_n;
  endproperty
  a_trim: assert property (p_trim)
    else $error("early access left fault pin high");

  property p_key_clears;
    wr && addr == REG_KEY && wdata == KEY_SECOND && key1_seen |-> ##[2:4] fault_n;
  endproperty
  a_key_clears: assert property (p_key_clears)
    else $error("software reset kept flags");

  property p_key_restart;
    wr && addr == REG_KEY && wdata == KEY_SECOND && key1_seen |-> ##[8:RS_HI] !fault_n;
  endproperty
  a_key_restart: assert property (p_key_restart)
    else $error("no restart flag after software reset");

  property p_pin_hold;
    !reset_pin_n [*4] |-> ##[0:3] fault_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("held reset pin kept flags");

  property p_pin_restart;
    $rose(reset_pin_n) |-> ##[8:RS_HI] !fault_n;
  endproperty
  a_pin_restart: assert property (p_pin_restart)
    else $error("no restart flag after pin reset");

  property p_clear;
    wr && addr == REG_LATCHED && wdata == CLEAR_ALL && sup_clr_seen |-> ##[1:3] fault_n;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault pin held after full clear");
endmodule

//--- verification/test_reset_and_fault_flag_logic.sv
// Bench for the host and device ends joined by the link interface.
// Assumes package, interface and both ends compiled first.
`timescale 1ns/100ps
module test_reset_and_fault_flag_logic;
  import rff_pkg::*;
  localparam int RCYC = 20;
  localparam int PCYC = 3;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        core_ok;
  logic        intf_ok;
  logic [8:0]  cond;
  logic        hit;
  logic        chan_hiz;
  logic        cal_reload;
  logic        in_reset;
  logic [15:0] chan_cfg;
  logic [15:0] v;
  int          error_cnt;
  int          tests_run;
  int          cyc;

  ////////////////////////////////////////////////////////////////////////////
  // Both ends across one link, checker beside it
  rff_link_if rff_link_if_inst ();
  rff_device #(.RESET_CYC(RCYC), .PULSE_CYC(PCYC)) rff_device_inst (
    .CLK(clk), .NRST(nrst), .LINK(rff_link_if_inst.dev),
    .CORE_SUPPLY_OK(core_ok), .INTF_SUPPLY_OK(intf_ok), .SUPPLY_LOW(cond[8:3]),
    .TEMP_ALERT(cond[0]), .TEMP_RESET_HIT(hit), .FRAME_ERR(cond[1]),
    .CHAN_FAULT(cond[2]), .CHAN_HIZ(chan_hiz), .CAL_RELOAD(cal_reload),
    .IN_RESET(in_reset), .CHAN_CFG(chan_cfg));
  rff_host #(.RESET_CYC(RCYC), .PULSE_CYC(PCYC)) rff_host_inst (
    .CLK(clk), .NRST(nrst), .LINK(rff_link_if_inst.host), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  rff_link_chk #(.RESET_CYC(RCYC)) rff_link_chk_inst (
    .CLK(clk), .NRST(nrst), .addr(rff_link_if_inst.addr),
    .wdata(rff_link_if_inst.wdata), .wr(rff_link_if_inst.wr), .rd(rff_link_if_inst.rd),
    .rdata(rff_link_if_inst.rdata), .reset_pin_n(rff_link_if_inst.reset_pin_n),
    .fault_n(rff_link_if_inst.fault_n));

  // Clock and hang guard; limit well above the expected run
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared bus and compare tasks
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic sw_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic sw_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Poll busy with a bound; a stuck host shows up in later checks
  task automatic ctrl(input logic [15:0] bits);
    int n;
    n = 0;
    sw_wr(HREG_CTRL, bits);
    v = 16'h0001;
    while (v[0] !== 1'b0 && n < 300)
    begin
      sw_rd(HREG_STATUS, v);
      n++;
    end
  endtask

  task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
    sw_wr(HREG_DADDR, {8'h00, a});
    sw_wr(HREG_DWDATA, d);
    ctrl(16'h0008);
  endtask

  task automatic dev_rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    sw_wr(HREG_DADDR, {8'h00, a});
    ctrl(16'h0010);
    sw_rd(HREG_DRDATA, v);
    check(name, exp, v);
  endtask

  task automatic fault_chk(input logic [15:0] exp);
    sw_rd(HREG_STATUS, v);
    check("fault pin", exp, v & 16'h0002);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_power_on();
    sw_wr(HREG_DADDR, {8'h00, REG_LATCHED});
    ctrl(16'h0010);
    repeat (RCYC + 5) @(posedge clk);
    dev_rd(REG_SUPPLY, 16'h0001, "trim incomplete");
    dev_rd(REG_LATCHED, 16'h0001, "restart flag");
    fault_chk(16'h0002);
    ctrl(16'h0004);
    dev_rd(REG_SUPPLY, 16'h0000, "supply cleared");
    dev_rd(REG_LATCHED, 16'h0000, "latched cleared");
    fault_chk(16'h0000);
  endtask

  task automatic t_flags();
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      cond <= 9'(1 << i);
      dev_rd(REG_LIVE, 16'(2 << i), "live flag");
      @(posedge clk);
      cond <= 9'h000;
      dev_rd(REG_LIVE, 16'h0000, "live gone");
      dev_rd(REG_LATCHED, 16'(2 << i), "sticky flag");
      fault_chk(16'h0002);
      dev_wr(REG_LATCHED, 16'(2 << i));
      dev_rd(REG_LATCHED, 16'h0000, "one bit clear");
    end
    @(posedge clk);
    cond <= 9'h1FF;
    dev_wr(REG_LATCHED, CLEAR_ALL);
    dev_rd(REG_LATCHED, 16'h03FE, "set wins");
    dev_wr(REG_MASK, 16'h03FE);
    fault_chk(16'h0000);
    @(posedge clk);
    cond <= 9'h000;
    dev_wr(REG_MASK, 16'h0000);
    fault_chk(16'h0002);
    dev_wr(REG_LATCHED, CLEAR_ALL);
    dev_rd(REG_LATCHED, 16'h0000, "clear all");
    fault_chk(16'h0000);
  endtask

  task automatic t_sw_reset();
    dev_wr(REG_MASK, 16'h00F0);
    dev_wr(REG_OVERHEAT, 16'h0001);
    dev_rd(REG_OVERHEAT, 16'h0001, "enable set");
    dev_wr(REG_KEY, KEY_FIRST);
    dev_wr(REG_CHAN, 16'h5678);
    dev_wr(REG_KEY, KEY_SECOND);
    dev_rd(REG_CHAN, 16'h5678, "chan kept");
    dev_rd(REG_KEY, 16'h0000, "key reads zero");
    // Leave a frame flag up so the reset has something to clear
    @(posedge clk);
    cond <= 9'h002;
    @(posedge clk);
    cond <= 9'h000;
    fault_chk(16'h0002);
    ctrl(16'h0002);
    fault_chk(16'h0000);
    dev_rd(REG_CHAN, CHAN_RST, "chan default");
    dev_rd(REG_MASK, MASK_RST, "mask default");
    dev_rd(REG_OVERHEAT, 16'h0000, "restart enable");
    check("cfg port", CHAN_RST, chan_cfg);
    check("hi-z", 16'h0001, {15'h0000, chan_hiz});
  endtask

  task automatic t_overheat();
    @(posedge clk);
    hit <= 1'b1;
    dev_wr(REG_CHAN, 16'h00A5);
    check("cfg set", 16'h00A5, chan_cfg);
    check("hi-z off", 16'h0000, {15'h0000, chan_hiz});
    check("no heat reset", 16'h0000, {15'h0000, in_reset});
    dev_wr(REG_OVERHEAT, 16'h0001);
    check("heat reset", 16'h0001, {15'h0000, in_reset});
    repeat (RCYC + 5) @(posedge clk);
    check("enable gone", 16'h0000, {15'h0000, in_reset});
    hit <= 1'b0;
    dev_rd(REG_CHAN, CHAN_RST, "heat chan");
    dev_rd(REG_LATCHED, 16'h0001, "heat restart");
    ctrl(16'h0004);
  endtask

  task automatic t_pin_and_supply();
    dev_wr(REG_CHAN, 16'h00A5);
    // Channel fault flag up before the pin reset, so the hold check sees the fault pin rise
    @(posedge clk);
    cond <= 9'h004;
    @(posedge clk);
    cond <= 9'h000;
    fault_chk(16'h0002);
    ctrl(16'h0001);
    dev_rd(REG_CHAN, CHAN_RST, "pin chan");
    @(posedge clk);
    core_ok <= 1'b0;
    repeat (RCYC + 5) @(posedge clk);
    check("core low", 16'h0001, {15'h0000, in_reset});
    core_ok <= 1'b1;
    intf_ok <= 1'b0;
    repeat (RCYC + 5) @(posedge clk);
    check("intf low", 16'h0001, {15'h0000, in_reset});
    intf_ok <= 1'b1;
    repeat (3) @(posedge clk);
    check("cal reload", 16'h0001, {15'h0000, cal_reload});
    repeat (RCYC + 2) @(posedge clk);
    check("supplies good", 16'h0000, {15'h0000, in_reset});
    check("reload done", 16'h0000, {15'h0000, cal_reload});
    dev_rd(REG_LATCHED, 16'h0001, "supply restart");
    ctrl(16'h0004);
    fault_chk(16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, the only exit
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: 12 cycles of reset, then the scenarios
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    core_ok = 1'b1;
    intf_ok = 1'b1;
    cond = 9'h000;
    hit = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_power_on();
    t_flags();
    t_sw_reset();
    t_overheat();
    t_pin_and_supply();
    report_and_stop();
  end
endmodule
